// ===== tsc_pkg.sv
// constants shared by the timer control/status block
package tsc_pkg;
  // register indices as printed; the byte address is four times the index
  localparam logic [29:0] IDX_CTRL_STATUS = 30'h00ffff6b;
  localparam logic [29:0] IDX_TIME_CONST_A = 30'h00ffff6d;
  localparam logic [29:0] IDX_TIME_CONST_B = 30'h00ffff6e;
  localparam logic [29:0] IDX_UP_COUNTER = 30'h00ffff71;
  localparam logic [29:0] IDX_RUN_CTRL = 30'h00ffff80;
  localparam logic [29:0] IDX_IRQ_STATUS = 30'h00ffff81;
  localparam logic [29:0] IDX_IRQ_MASK = 30'h00ffff82;

  // register select codes held through the data phase
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_CS = 3'h1;
  localparam logic [2:0] SEL_TCA = 3'h2;
  localparam logic [2:0] SEL_TCB = 3'h3;
  localparam logic [2:0] SEL_CNT = 3'h4;
  localparam logic [2:0] SEL_RUN = 3'h5;
  localparam logic [2:0] SEL_ISTAT = 3'h6;
  localparam logic [2:0] SEL_IMASK = 3'h7;

  // control/status field positions
  localparam int BIT_MATCH_B_FLAG = 7;
  localparam int BIT_MATCH_A_FLAG = 6;
  localparam int BIT_WRAP_FLAG = 5;
  localparam int BIT_CONV_TRIG_EN = 4;
  localparam int BIT_OS_B_HI = 3;
  localparam int BIT_OS_B_LO = 2;
  localparam int BIT_OS_A_HI = 1;
  localparam int BIT_OS_A_LO = 0;

  // interrupt status and mask bit positions
  localparam int IRQ_WRAP = 0;
  localparam int IRQ_MATCH_A = 1;
  localparam int IRQ_MATCH_B = 2;

  // output-select encodings
  localparam logic [1:0] OS_HOLD = 2'h0;
  localparam logic [1:0] OS_LOW = 2'h1;
  localparam logic [1:0] OS_HIGH = 2'h2;
  localparam logic [1:0] OS_TOGGLE = 2'h3;

  // values after reset, plus the counter maximum and step
  localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
  localparam logic [7:0] RST_COUNTER = 8'h00;
  localparam logic [7:0] RST_TIME_CONST = 8'hff;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_STEP = 8'h01;
endpackage

// ===== tsc_match.sv
// one compare unit: counter against a time constant
module tsc_match (
  input wire logic [7:0] count,
  input wire logic [7:0] constant,
  input wire logic suppress,
  output logic match
);
  // a pending constant write blocks the compare for that cycle
  assign match = !suppress && (count == constant);
endmodule

// ===== tsc_timer.sv
// timer channel: counter, compare, control/status register and AHB-Lite slave
// Functional notes
// - counter equal to constant B sets the B match flag, bit 7.
// - counter equal to constant A sets the A match flag, bit 6.
// - counter overflow sets the wrap flag, bit 5.
// - bit 4 gates the conversion start request made on match A.
// - output select B of 00 leaves the output pin unchanged on match B.
// - output select A of 00 leaves the output pin unchanged on match A.
// - flags, trigger enable and output selects share one 8-bit register.
// - each counter wrap from ff to 00 sets the wrap flag.
// - compare runs always except in the data phase of a constant write.
// - counter is an 8-bit readable, writable up counter starting at zero.
module tsc_timer
  import tsc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic timer_output_pin,
  output logic conv_start,
  output logic irq
);

  typedef struct packed {
    logic dp_valid;
    logic dp_write;
    logic [2:0] dp_sel;
    logic [7:0] up_counter;
    logic [7:0] time_constant_a;
    logic [7:0] time_constant_b;
    logic [7:0] timer_ctrl_status;
    logic [2:0] flag_seen;
    logic run;
    logic match_a_d;
    logic match_b_d;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic pin;
    logic trig;
    logic irq;
    logic rdy;
    logic resp;
    logic [31:0] rdata;
  } tsc_state_s;

  tsc_state_s s_ff;
  tsc_state_s nxt_s;

  logic wr_now;
  logic suppress;
  logic match_a;
  logic match_b;
  logic ev_a;
  logic ev_b;
  logic inc;
  logic wrap_ev;
  logic addr_phase;
  logic [2:0] addr_sel;
  logic [7:0] rd_byte;
  logic [1:0] os_a;
  logic [1:0] os_b;

  // address decode of the word index; unmapped words read zero, ignore writes
  always_comb begin
    case (haddr[31:2])
      IDX_CTRL_STATUS: addr_sel = SEL_CS;
      IDX_TIME_CONST_A: addr_sel = SEL_TCA;
      IDX_TIME_CONST_B: addr_sel = SEL_TCB;
      IDX_UP_COUNTER: addr_sel = SEL_CNT;
      IDX_RUN_CTRL: addr_sel = SEL_RUN;
      IDX_IRQ_STATUS: addr_sel = SEL_ISTAT;
      IDX_IRQ_MASK: addr_sel = SEL_IMASK;
      default: addr_sel = SEL_NONE;
    endcase
  end

  // write data phase; a constant write blanks both compares that cycle
  assign wr_now = s_ff.dp_valid && s_ff.dp_write;
  assign suppress = wr_now && (s_ff.dp_sel == SEL_TCA || s_ff.dp_sel == SEL_TCB);
  assign addr_phase = hsel && hready && htrans[1];

  tsc_match u_match_a (
    .count(s_ff.up_counter),
    .constant(s_ff.time_constant_a),
    .suppress(suppress),
    .match(match_a)
  );

  tsc_match u_match_b (
    .count(s_ff.up_counter),
    .constant(s_ff.time_constant_b),
    .suppress(suppress),
    .match(match_b)
  );

  // events fire on the rising edge of a match, so a stopped counter
  // sitting on a constant does not re-trigger the pin every cycle
  assign ev_a = match_a && !s_ff.match_a_d;
  assign ev_b = match_b && !s_ff.match_b_d;
  // a software write to the counter beats the increment
  assign inc = s_ff.run && !(wr_now && s_ff.dp_sel == SEL_CNT);
  assign wrap_ev = inc && (s_ff.up_counter == CNT_MAX);
  assign os_a = s_ff.timer_ctrl_status[BIT_OS_A_HI:BIT_OS_A_LO];
  assign os_b = s_ff.timer_ctrl_status[BIT_OS_B_HI:BIT_OS_B_LO];

  // next-state logic for the whole block
  always_comb begin
    nxt_s = s_ff;
    rd_byte = 8'h00;
    nxt_s.match_a_d = match_a;
    nxt_s.match_b_d = match_b;
    nxt_s.resp = 1'b0;
    nxt_s.rdy = 1'b1;

    // counter: write, else count up and roll over
    if (wr_now && s_ff.dp_sel == SEL_CNT) begin
      nxt_s.up_counter = hwdata[7:0];
    end else if (inc) begin
      nxt_s.up_counter = s_ff.up_counter + CNT_STEP;
    end

    if (wr_now && s_ff.dp_sel == SEL_TCA) begin
      nxt_s.time_constant_a = hwdata[7:0];
    end
    if (wr_now && s_ff.dp_sel == SEL_TCB) begin
      nxt_s.time_constant_b = hwdata[7:0];
    end
    if (wr_now && s_ff.dp_sel == SEL_RUN) begin
      nxt_s.run = hwdata[0];
    end
    if (wr_now && s_ff.dp_sel == SEL_IMASK) begin
      nxt_s.irq_mask = hwdata[2:0];
    end

    // control/status write: plain bits load, a flag clears only on 0 after seen as 1
    if (wr_now && s_ff.dp_sel == SEL_CS) begin
      nxt_s.timer_ctrl_status[BIT_CONV_TRIG_EN:0] = hwdata[BIT_CONV_TRIG_EN:0];
      for (int i = 0; i < 3; i++) begin
        if (!hwdata[BIT_WRAP_FLAG + i] && s_ff.flag_seen[i]) begin
          nxt_s.timer_ctrl_status[BIT_WRAP_FLAG + i] = 1'b0;
          nxt_s.flag_seen[i] = 1'b0;
        end
      end
    end

    // hardware sets come last so an event in a clearing cycle is kept
    if (ev_b) begin
      nxt_s.timer_ctrl_status[BIT_MATCH_B_FLAG] = 1'b1;
    end
    if (ev_a) begin
      nxt_s.timer_ctrl_status[BIT_MATCH_A_FLAG] = 1'b1;
    end
    if (wrap_ev) begin
      nxt_s.timer_ctrl_status[BIT_WRAP_FLAG] = 1'b1;
    end

    // interrupt status: write one to clear, set wins
    if (wr_now && s_ff.dp_sel == SEL_ISTAT) begin
      nxt_s.irq_status = s_ff.irq_status & ~hwdata[2:0];
    end
    nxt_s.irq_status[IRQ_WRAP] = nxt_s.irq_status[IRQ_WRAP] | wrap_ev;
    nxt_s.irq_status[IRQ_MATCH_A] = nxt_s.irq_status[IRQ_MATCH_A] | ev_a;
    nxt_s.irq_status[IRQ_MATCH_B] = nxt_s.irq_status[IRQ_MATCH_B] | ev_b;
    nxt_s.irq = |(nxt_s.irq_status & nxt_s.irq_mask);

    // conversion start pulse, gated by the trigger enable
    nxt_s.trig = ev_a && s_ff.timer_ctrl_status[BIT_CONV_TRIG_EN];

    // output pin: B applied first, A last, so A wins a tie
    if (ev_b) begin
      case (os_b)
        OS_HOLD: nxt_s.pin = nxt_s.pin;
        OS_LOW: nxt_s.pin = 1'b0;
        OS_HIGH: nxt_s.pin = 1'b1;
        OS_TOGGLE: nxt_s.pin = !nxt_s.pin;
        default: nxt_s.pin = nxt_s.pin;
      endcase
    end
    if (ev_a) begin
      case (os_a)
        OS_HOLD: nxt_s.pin = nxt_s.pin;
        OS_LOW: nxt_s.pin = 1'b0;
        OS_HIGH: nxt_s.pin = 1'b1;
        OS_TOGGLE: nxt_s.pin = !nxt_s.pin;
        default: nxt_s.pin = nxt_s.pin;
      endcase
    end

    // read data comes from the next state so a read right after a write
    // sees the written value; zero wait states, so it is latched now
    case (addr_sel)
      SEL_CS: rd_byte = nxt_s.timer_ctrl_status;
      SEL_TCA: rd_byte = nxt_s.time_constant_a;
      SEL_TCB: rd_byte = nxt_s.time_constant_b;
      SEL_CNT: rd_byte = nxt_s.up_counter;
      SEL_RUN: rd_byte = {7'h00, nxt_s.run};
      SEL_ISTAT: rd_byte = {5'h00, nxt_s.irq_status};
      SEL_IMASK: rd_byte = {5'h00, nxt_s.irq_mask};
      default: rd_byte = 8'h00;
    endcase

    // address phase capture; hsize is ignored, only whole words are used
    nxt_s.dp_valid = addr_phase;
    nxt_s.dp_write = addr_phase && hwrite;
    nxt_s.dp_sel = addr_phase ? addr_sel : SEL_NONE;
    if (addr_phase && !hwrite) begin
      nxt_s.rdata = {24'h000000, rd_byte};
      if (addr_sel == SEL_CS) begin
        // flags seen as 1 now arm the clear-by-zero
        nxt_s.flag_seen = nxt_s.flag_seen |
          nxt_s.timer_ctrl_status[BIT_MATCH_B_FLAG:BIT_WRAP_FLAG];
      end
    end
  end

  // all state in one register; clock enable low freezes everything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '0;
      s_ff.up_counter <= RST_COUNTER;
      s_ff.time_constant_a <= RST_TIME_CONST;
      s_ff.time_constant_b <= RST_TIME_CONST;
      s_ff.timer_ctrl_status <= RST_CTRL_STATUS;
      s_ff.rdy <= 1'b1;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign hrdata = s_ff.rdata;
  assign hreadyout = s_ff.rdy;
  assign hresp = s_ff.resp;
  assign timer_output_pin = s_ff.pin;
  assign conv_start = s_ff.trig;
  assign irq = s_ff.irq;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_MATCH_B_SETS: assert property (ce && ev_b |=> s_ff.timer_ctrl_status[7])
    else $error("match b did not set its flag");
  AST_MATCH_A_SETS: assert property (ce && ev_a |=> s_ff.timer_ctrl_status[6])
    else $error("match a did not set its flag");
  AST_WRAP_SETS: assert property (ce && s_ff.run && s_ff.up_counter == 8'hff
    && !(wr_now && s_ff.dp_sel == SEL_CNT) |=> s_ff.timer_ctrl_status[5] && s_ff.up_counter == 8'h00)
    else $error("wrap did not set flag or reach zero");
  AST_TRIG_GATE: assert property (ce |=> conv_start == $past(ev_a &&
    s_ff.timer_ctrl_status[4]))
    else $error("conversion start not gated by enable");
  AST_OS_B_HOLD: assert property (ce && ev_b && !ev_a && os_b == 2'h0
    |=> $stable(timer_output_pin))
    else $error("pin moved on match b with select 00");
  AST_OS_A_HOLD: assert property (ce && ev_a && !ev_b && os_a == 2'h0
    |=> $stable(timer_output_pin))
    else $error("pin moved on match a with select 00");
  AST_CS_READ: assert property (ce && addr_phase && !hwrite && addr_sel == SEL_CS
    |=> hrdata == {24'h000000, s_ff.timer_ctrl_status})
    else $error("status read returned wrong value");
  AST_SUPPRESS: assert property (suppress |-> !match_a && !match_b)
    else $error("compare active during constant write");
  AST_COUNT_UP: assert property (ce && s_ff.run && !wr_now |=>
    s_ff.up_counter == $past(s_ff.up_counter) + 8'h01)
    else $error("counter did not step by one");
  AST_STICKY: assert property (ce && s_ff.timer_ctrl_status[5] && !wr_now
    |=> s_ff.timer_ctrl_status[5])
    else $error("wrap flag dropped without a write");
  // a flag may only rise on its own event; a stray set would fake an event seen by a status read
  AST_MATCH_B_ONLY: assert property (ce && !s_ff.timer_ctrl_status[BIT_MATCH_B_FLAG]
    && s_ff.up_counter != s_ff.time_constant_b |=> !s_ff.timer_ctrl_status[BIT_MATCH_B_FLAG])
    else $error("match b flag rose without a match");
  AST_MATCH_A_ONLY: assert property (ce && !s_ff.timer_ctrl_status[BIT_MATCH_A_FLAG]
    && s_ff.up_counter != s_ff.time_constant_a |=> !s_ff.timer_ctrl_status[BIT_MATCH_A_FLAG])
    else $error("match a flag rose without a match");
  AST_WRAP_ONLY: assert property (ce && !s_ff.timer_ctrl_status[BIT_WRAP_FLAG]
    && !(s_ff.run && s_ff.up_counter == CNT_MAX) |=> !s_ff.timer_ctrl_status[BIT_WRAP_FLAG])
    else $error("wrap flag rose without a counter wrap");
  AST_CNT_LOAD: assert property (ce && wr_now && s_ff.dp_sel == SEL_CNT
    |=> s_ff.up_counter == $past(hwdata[7:0]))
    else $error("counter write did not load the value");
  // enable low must hold every bit of state, bus slave included
  AST_CE_FREEZE: assert property (!ce |=> $stable(s_ff))
    else $error("state moved while the clock enable was low");

  COV_WRAP: cover property (ce && wrap_ev);
  COV_TRIG: cover property (conv_start);
  COV_IRQ: cover property (irq);
  COV_CLEAR: cover property (s_ff.timer_ctrl_status[5] ##1 !s_ff.timer_ctrl_status[5]);
  COV_PIN_MOVE: cover property (ce && ev_b && os_b != OS_HOLD);

endmodule

// ===== tsc_timer_tb.sv
// self-checking bench for the timer control/status block
module tsc_timer_tb
  import tsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // one bus access: write rows carry data, read rows the expected value
  typedef struct packed {logic [29:0] idx; logic wr; logic [7:0] val;} tsc_row_s;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pin;
  logic conv_start;
  logic irq;
  logic [31:0] rd;
  int miscompares = 0;
  int checks_done = 0;
  int pulses;
  int pin_bad;

  tsc_row_s rows [16] = '{
    '{IDX_CTRL_STATUS, 1'b0, 8'h00},
    '{IDX_TIME_CONST_A, 1'b0, 8'hff},
    '{IDX_TIME_CONST_B, 1'b0, 8'hff},
    '{IDX_UP_COUNTER, 1'b0, 8'h00},
    '{30'h00ffff70, 1'b0, 8'h00},
    '{IDX_CTRL_STATUS, 1'b1, 8'hff},
    '{IDX_CTRL_STATUS, 1'b0, 8'h1f},
    '{IDX_CTRL_STATUS, 1'b1, 8'h00},
    '{IDX_UP_COUNTER, 1'b1, 8'h55},
    '{IDX_UP_COUNTER, 1'b0, 8'h55},
    '{IDX_UP_COUNTER, 1'b1, 8'h00},
    '{IDX_TIME_CONST_A, 1'b1, 8'h0f},
    '{IDX_TIME_CONST_B, 1'b1, 8'h20},
    '{IDX_IRQ_MASK, 1'b1, 8'h07},
    '{30'h00ffff70, 1'b1, 8'h5a},
    '{30'h00ffff70, 1'b0, 8'h00}
  };

  // single slave, so its own ready closes the loop
  assign hready = hreadyout;

  tsc_timer DUT (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_output_pin(pin), .conv_start(conv_start), .irq(irq)
  );

  // 200 MHz clock
  always #2.5 hclk = ~hclk;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // bounded wait for ready; a slave that never answers ends the run
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      $display("mismatch hready expected 1 seen %b", hreadyout);
      test_done();
    end
  endtask

  // address phase held until ready, then data phase until ready again
  task automatic xfer(input logic [29:0] idx, input logic wr, input logic [7:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_rdy();
    r = hrdata;
  endtask

  task automatic wr(input logic [29:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d, rd);
  endtask

  task automatic rd_chk(input string nm, input logic [29:0] idx, input logic [7:0] exp);
    xfer(idx, 1'b0, 8'h00, rd);
    chk(nm, {24'h000000, exp}, rd);
    chk("response okay", 32'd0, hresp);
  endtask

  // counts trigger pulses and cycles with the output pin not low
  task automatic watch(input int n);
    pulses = 0;
    pin_bad = 0;
    repeat (n) begin
      @(posedge hclk);
      if (conv_start === 1'b1) pulses++;
      if (pin !== 1'b0) pin_bad++;
    end
  endtask

  // hang guard in case a task wait is never reached
  initial begin
    #200000;
    miscompares++;
    $display("mismatch run time expected end seen timeout");
    test_done();
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      xfer(rows[i].idx, rows[i].wr, rows[i].val, rd);
      if (!rows[i].wr) chk("table read", {24'h000000, rows[i].val}, rd);
    end
    // count up through both constants with the trigger enabled
    wr(IDX_CTRL_STATUS, 8'h10);
    wr(IDX_RUN_CTRL, 8'h01);
    watch(200);
    wr(IDX_RUN_CTRL, 8'h00);
    chk("trigger pulses", 32'd1, pulses);
    chk("pin held", 32'd0, pin_bad);
    chk("irq raised", 32'd1, irq);
    // a zero written before any read must not clear the flags
    wr(IDX_CTRL_STATUS, 8'h10);
    rd_chk("flags kept", IDX_CTRL_STATUS, 8'hd0);
    wr(IDX_CTRL_STATUS, 8'h10);
    rd_chk("flags cleared", IDX_CTRL_STATUS, 8'h10);
    wr(IDX_IRQ_STATUS, 8'h07);
    @(posedge hclk);
    chk("irq cleared", 32'd0, irq);
    // wrap past ff and through match a with the trigger disabled
    wr(IDX_CTRL_STATUS, 8'h00);
    wr(IDX_UP_COUNTER, 8'hf0);
    wr(IDX_RUN_CTRL, 8'h01);
    watch(30);
    wr(IDX_RUN_CTRL, 8'h00);
    chk("pulses gated", 32'd0, pulses);
    rd_chk("wrap and match a", IDX_CTRL_STATUS, 8'h60);
    // select b set to high: the counter runs from 11 to 25, match b at 20 drives the pin
    wr(IDX_CTRL_STATUS, 8'h08);
    wr(IDX_RUN_CTRL, 8'h01);
    repeat (20) @(posedge hclk);
    chk("pin on match b", 32'd1, pin);
    // reset in mid-run returns everything to its start values
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    chk("pin after reset", 32'd0, pin);
    chk("irq after reset", 32'd0, irq);
    rd_chk("status after reset", IDX_CTRL_STATUS, 8'h00);
    rd_chk("counter after reset", IDX_UP_COUNTER, 8'h00);
    rd_chk("constant after reset", IDX_TIME_CONST_A, 8'hff);
    // enable low for ten cycles: only the three cycles of the stop write count
    wr(IDX_RUN_CTRL, 8'h01);
    ce <= 1'b0;
    repeat (10) @(posedge hclk);
    ce <= 1'b1;
    wr(IDX_RUN_CTRL, 8'h00);
    rd_chk("counter frozen by enable", IDX_UP_COUNTER, 8'h03);
    test_done();
  end
endmodule
